// ---- hdl/tas_defines.vh ----
`ifndef TAS_DEFINES_VH
`define TAS_DEFINES_VH
// core clock rate and alarm timing
`define TAS_CLK_HZ            25000000
`define TAS_TICK_MS           100
`define TAS_TICK_CYCLES       ((`TAS_CLK_HZ / 1000) * `TAS_TICK_MS)
`define TAS_YELLOW_DECL_TENTHS 9'h01b
`define TAS_TIME_MIN          9'h001
`define TAS_TIME_MAX          9'h12c
`define TAS_TIME_RESET        9'h00a
// channel layout
`define TAS_CHANNELS          24
`define TAS_CHAN_W            5
`define TAS_FRAME_W           5
`define TAS_D4_FRAMES         5'h0c
`define TAS_ESF_FRAMES        5'h18
`define TAS_RBS_PERIOD        5'h06
// circuit kinds presented on cross-connect
`define TAS_KIND_VOICE        3'h0
`define TAS_KIND_DATA         3'h1
`define TAS_KIND_SWITCHED_56K_MODE         3'h2
`define TAS_KIND_CTRL         3'h3
`define TAS_KIND_BYPASS       3'h4
`endif

// ---- hdl/tas_alarm_channel.v ----
// Function
// - declaration_time_setting alarm after fault persists declaration time
// - red declaration time 1..300 tenths
// - yellow declaration fixed 2.7 s
// - clear after fault absent clearing time
// - clearing time 1..300 tenths
// - new times take effect at restart
// - ESF red alarm on aggregate link sends yellow to far end
// - newer convention: yellow until red clears
// - older convention: yellow stops on resync
// - release choice: resync or red clear
// - release choice only honoured under ESF
// - conventions alter only ESF behaviour
// - 24 channels, per-channel configuration
// - D4 overwrite LSB frames 6, 12
// - ESF overwrite LSB frames 6,12,18,24
// - signalling default on, cross-connect defaults
// - inversion complements all payload bits
// - cross-connect inversion defaults by kind
// - bypass connections default no inversion
// - red fault is frame alignment loss
// - yellow fault is far-end alarm indication
`timescale 1ns/1ns
`include "tas_defines.vh"
module tas_alarm_channel #(
	parameter TICK_CYCLES = `TAS_TICK_CYCLES,
	parameter CHANNELS    = `TAS_CHANNELS
) (
	// clock and reset
	input  wire       core_clk,
	input  wire       reset,

	// line status pins
	input  wire       frame_lost_pin,
	input  wire       far_alarm_pin,

	// configuration
	input  wire       esf_mode,
	input  wire [8:0] declaration_time_setting,
	input  wire [8:0] clearing_time_setting,
	input  wire       remote_alarm_release_choice,
	input  wire       aggregate_link,

	// per-channel configuration writes
	input  wire       chan_cfg_we,
	input  wire [4:0] chan_cfg_idx,
	input  wire       chan_cfg_rbs,
	input  wire       chan_cfg_invert,

	// cross-connect event
	input  wire       xconn_we,
	input  wire [4:0] xconn_idx,
	input  wire [2:0] xconn_kind,

	// outgoing payload stream
	input  wire       pay_valid,
	input  wire [4:0] pay_frame,
	input  wire [4:0] pay_chan,
	input  wire [7:0] pay_data,
	input  wire       pay_sig_bit,

	// alarm status
	output reg        red_alarm_reg,
	output reg        yellow_alarm_reg,
	output reg        send_yellow_reg,

	// processed stream
	output reg        out_valid_reg,
	output reg  [7:0] out_data_reg,

	// channel status readback
	output wire       lsb_signalling_enabled,
	output wire       lsb_signalling_disabled,
	output wire       chan_invert_state
);

	localparam release_on_resync            = 1'b0;
	localparam release_on_local_alarm_clear = 1'b1;

	// timing notes
	// - every time setting is in tenths of a second
	// - a zero or oversize setting is pulled into 1..300
	// - a new setting is taken only while a timer is idle
	// - so a change during a running count waits for it

	// clamp a programmed time into the legal window
	function [8:0] clamp_time;
		input [8:0] t;
		begin
			if (t < `TAS_TIME_MIN)
				clamp_time = `TAS_TIME_MIN;
			else if (t > `TAS_TIME_MAX)
				clamp_time = `TAS_TIME_MAX;
			else
				clamp_time = t;
		end
	endfunction

	// line pins come from outside the clock domain
	// - first stage may go metastable, never decoded
	// - a level counts once stages two and three agree
	// - adds three to four cycles before any timer starts

	// three-stage synchronisers for line pins
	reg [2:0] lost_sync_reg;
	reg [2:0] far_sync_reg;
	reg       lost_reg;
	reg       far_reg;
	always @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			lost_sync_reg <= 3'h0;
			far_sync_reg  <= 3'h0;
			lost_reg      <= 1'b0;
			far_reg       <= 1'b0;
		end
		else
		begin
			lost_sync_reg <= {lost_sync_reg[1:0], frame_lost_pin};
			far_sync_reg  <= {far_sync_reg[1:0], far_alarm_pin};
			if (lost_sync_reg[2] == lost_sync_reg[1])
				lost_reg <= lost_sync_reg[2];
			if (far_sync_reg[2] == far_sync_reg[1])
				far_reg <= far_sync_reg[2];
		end
	end

	// shared time base for both alarm timers
	// - free running, so the first tick of a count is partial
	// - a limit of n ticks therefore spans n-1 to n periods

	// 100 ms tick generator
	reg  [21:0] tick_cnt_reg;
	wire        tick = (tick_cnt_reg == TICK_CYCLES - 1);
	always @(posedge core_clk or posedge reset)
	begin
		if (reset)
			tick_cnt_reg <= 22'h0;
		else if (tick)
			tick_cnt_reg <= 22'h0;
		else
			tick_cnt_reg <= tick_cnt_reg + 22'h1;
	end

	// red alarm follows frame alignment loss
	// - counting only while the synced level differs from the alarm
	// - any return to agreement restarts the count from zero
	// - declaration_time_setting limit while clear, clearing limit while raised
	// - a short outage never raises the alarm

	// red timer: counts while condition differs from alarm state
	reg  [8:0] red_cnt_reg;
	reg  [8:0] red_limit_reg;
	wire       red_pending = (lost_reg != red_alarm_reg);
	always @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			red_cnt_reg   <= 9'h0;
			red_limit_reg <= `TAS_TIME_RESET;
			red_alarm_reg <= 1'b0;
		end
		else if (!red_pending)
		begin
			red_cnt_reg   <= 9'h0;
			// latch new limit only while idle
			red_limit_reg <= red_alarm_reg ? clamp_time(clearing_time_setting)
				: clamp_time(declaration_time_setting);
		end
		else if (tick)
		begin
			if (red_cnt_reg + 9'h1 >= red_limit_reg)
			begin
				red_alarm_reg <= lost_reg;
				red_cnt_reg   <= 9'h0;
			end
			else
				red_cnt_reg <= red_cnt_reg + 9'h1;
		end
	end

	// yellow alarm follows the far-end indication
	// - declaration fixed, not programmable
	// - clearing uses the same setting as red
	// - same restart behaviour as the red timer

	// yellow timer: fixed 2.7 s declaration, shared clearing time
	reg  [8:0] yel_cnt_reg;
	reg  [8:0] yel_limit_reg;
	wire       yel_pending = (far_reg != yellow_alarm_reg);
	always @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			yel_cnt_reg      <= 9'h0;
			yel_limit_reg    <= `TAS_YELLOW_DECL_TENTHS;
			yellow_alarm_reg <= 1'b0;
		end
		else if (!yel_pending)
		begin
			yel_cnt_reg   <= 9'h0;
			yel_limit_reg <= yellow_alarm_reg ? clamp_time(clearing_time_setting)
				: `TAS_YELLOW_DECL_TENTHS;
		end
		else if (tick)
		begin
			if (yel_cnt_reg + 9'h1 >= yel_limit_reg)
			begin
				yellow_alarm_reg <= far_reg;
				yel_cnt_reg      <= 9'h0;
			end
			else
				yel_cnt_reg <= yel_cnt_reg + 9'h1;
		end
	end

	// yellow sent back while red is raised
	// - ESF: only for faults on the aggregate link
	// - newer convention holds it until red clears
	// - older convention drops it on regained alignment
	// - D4 ignores the release choice entirely
	// - far end then applies its own clearing time

	// outgoing yellow towards far end
	wire release_mode = esf_mode ? remote_alarm_release_choice
		: release_on_local_alarm_clear;
	always @(posedge core_clk or posedge reset)
	begin
		if (reset)
			send_yellow_reg <= 1'b0;
		else if (!red_alarm_reg)
			send_yellow_reg <= 1'b0;
		else if (release_mode == release_on_resync && !lost_reg)
			send_yellow_reg <= 1'b0;
		else
			send_yellow_reg <= aggregate_link | !esf_mode;
	end

	// one signalling and one inversion bit per channel
	// - reset: signalling on, no inversion everywhere
	// - cross-connect kind sets defaults, wins over a write
	// - voice leaves signalling as it was
	// - control channel defaults change on the aggregate only

	// per-channel configuration arrays
	reg [CHANNELS-1:0] rbs_en_reg;
	reg [CHANNELS-1:0] inv_reg;
	always @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			rbs_en_reg <= {CHANNELS{1'b1}};
			inv_reg    <= {CHANNELS{1'b0}};
		end
		else if (xconn_we && xconn_idx < CHANNELS)
		begin
			case (xconn_kind)
			`TAS_KIND_VOICE:
			begin
				inv_reg[xconn_idx] <= 1'b1;
			end
			`TAS_KIND_DATA:
			begin
				rbs_en_reg[xconn_idx] <= 1'b0;
				inv_reg[xconn_idx]    <= 1'b0;
			end
			`TAS_KIND_SWITCHED_56K_MODE:
			begin
				rbs_en_reg[xconn_idx] <= 1'b1;
				inv_reg[xconn_idx]    <= 1'b0;
			end
			`TAS_KIND_CTRL:
			begin
				if (aggregate_link)
				begin
					rbs_en_reg[xconn_idx] <= 1'b0;
					inv_reg[xconn_idx]    <= 1'b0;
				end
			end
			`TAS_KIND_BYPASS:
			begin
				inv_reg[xconn_idx] <= 1'b0;
			end
			default:
			begin
				inv_reg[xconn_idx] <= inv_reg[xconn_idx];
			end
			endcase
		end
		else if (chan_cfg_we && chan_cfg_idx < CHANNELS)
		begin
			rbs_en_reg[chan_cfg_idx] <= chan_cfg_rbs;
			inv_reg[chan_cfg_idx]    <= chan_cfg_invert;
		end
	end

	// status of the channel named by the write index
	// - out-of-range index reads as all zero

	// readback for the addressed channel
	wire cfg_hit = (chan_cfg_idx < CHANNELS);
	assign lsb_signalling_enabled  = cfg_hit & rbs_en_reg[chan_cfg_idx];
	assign lsb_signalling_disabled = cfg_hit & ~rbs_en_reg[chan_cfg_idx];
	assign chan_invert_state       = cfg_hit & inv_reg[chan_cfg_idx];

	// robbed frames: 6 and 12 in D4, 6 to 24 step 6 in ESF
	// - frame zero or beyond the superframe never robbed
	// - inversion applied before the lsb is replaced
	// - data channels must have signalling turned off

	// signalling frame decode: every sixth frame
	wire [4:0] frame_top = esf_mode ? `TAS_ESF_FRAMES : `TAS_D4_FRAMES;
	wire       sig_frame = (pay_frame != 5'h0) && (pay_frame <= frame_top)
		&& ((pay_frame % `TAS_RBS_PERIOD) == 5'h0);
	wire       chan_ok   = (pay_chan < CHANNELS);
	wire       ch_rbs    = chan_ok & rbs_en_reg[pay_chan];
	wire       ch_inv    = chan_ok & inv_reg[pay_chan];
	wire [7:0] inv_data  = ch_inv ? ~pay_data : pay_data;

	// one cycle of latency on the stream
	// - data holds between valid bytes
	// - valid follows input valid exactly

	// lsb_signalling_overwrite and inversion of the payload
	always @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			out_valid_reg <= 1'b0;
			out_data_reg  <= 8'h00;
		end
		else
		begin
			out_valid_reg <= pay_valid;
			if (pay_valid)
			begin
				if (ch_rbs && sig_frame)
					out_data_reg <= {inv_data[7:1], pay_sig_bit};
				else
					out_data_reg <= inv_data;
			end
		end
	end

endmodule // tas_alarm_channel

// ---- verif/tas_far_end.sv ----
`timescale 1ns/1ns
module tas_far_end (
	// line health commands from the bench
	input  wire lose_frame,
	input  wire far_fault,
	// yellow indication from the device
	input  wire send_yellow,
	// line pins toward the device
	output wire frame_lost_pin,
	output wire far_alarm_pin,
	// far circuits under trunk conditioning
	output wire conditioned
);
	// line status seen by the device
	assign frame_lost_pin = lose_frame;
	assign far_alarm_pin  = far_fault;
	// yellow receipt conditions circuits, released only when it stops
	assign conditioned = send_yellow;
endmodule // tas_far_end

// ---- verif/tas_alarm_channel_checker.sv ----
`timescale 1ns/1ns
module tas_alarm_checker (
	// clock and reset
	input wire       core_clk,
	input wire       reset,
	// watched ports
	input wire       frame_lost_pin,
	input wire       far_alarm_pin,
	input wire       esf_mode,
	input wire [4:0] chan_cfg_idx,
	input wire       pay_valid,
	input wire [4:0] pay_frame,
	input wire [4:0] pay_chan,
	input wire [7:0] pay_data,
	input wire       pay_sig_bit,
	input wire       red_alarm_reg,
	input wire       yellow_alarm_reg,
	input wire       send_yellow_reg,
	input wire       out_valid_reg,
	input wire [7:0] out_data_reg,
	input wire       lsb_signalling_enabled,
	input wire       lsb_signalling_disabled,
	input wire       chan_invert_state
);
	wire       rob;
	wire [7:0] exp_pay;
	// byte whose lsb is robbed, and the plain expected byte
	assign rob = pay_valid && lsb_signalling_enabled && chan_cfg_idx == pay_chan
		&& (pay_frame == 5'h06 || pay_frame == 5'h0c
		|| esf_mode && (pay_frame == 5'h12 || pay_frame == 5'h18));
	assign exp_pay = pay_data ^ {8{chan_invert_state}};
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	a_valid_follows: assert property (pay_valid |=> out_valid_reg)
		else $error("stream valid not echoed");
	a_valid_drops: assert property (!pay_valid |=> !out_valid_reg)
		else $error("stream valid without input");
	a_lsb_overwrite: assert property (rob |=> out_data_reg[0] == $past(pay_sig_bit))
		else $error("signalling bit not placed");
	a_payload_kept: assert property (pay_valid && chan_cfg_idx == pay_chan && !rob
		|=> out_data_reg == $past(exp_pay)) else $error("payload byte altered");
	a_red_cause: assert property ($rose(red_alarm_reg) |-> $past(frame_lost_pin, 3))
		else $error("red raised without fault");
	a_red_clear_cause: assert property ($fell(red_alarm_reg) |-> !$past(frame_lost_pin, 3))
		else $error("red cleared during fault");
	a_yellow_cause: assert property ($rose(yellow_alarm_reg) |-> $past(far_alarm_pin, 3))
		else $error("yellow raised without indication");
	a_yellow_in_red: assert property (send_yellow_reg |-> red_alarm_reg || $past(red_alarm_reg))
		else $error("yellow sent without red");
	a_lsb_readback: assert property (chan_cfg_idx < 5'h18
		|-> lsb_signalling_enabled != lsb_signalling_disabled) else $error("readback pair broken");
endmodule // tas_alarm_checker

// ---- verif/tas_alarm_channel_tb_top.sv ----
`timescale 1ns/1ns
module tas_alarm_channel_tb_top;
	logic       core_clk, reset, esf_mode, remote_alarm_release_choice, aggregate_link;
	logic       chan_cfg_we, chan_cfg_rbs, chan_cfg_invert, xconn_we, pay_valid, pay_sig_bit;
	logic       lose_frame, far_fault;
	logic [8:0] declaration_time_setting, clearing_time_setting;
	logic [4:0] chan_cfg_idx, xconn_idx, pay_frame, pay_chan;
	logic [2:0] xconn_kind;
	logic [7:0] pay_data;
	logic [7:0] xt [5] = '{8'h3a, 8'h03, 8'h44, 8'h7a, 8'h9c};
	wire        frame_lost_pin, far_alarm_pin, red_alarm_reg, yellow_alarm_reg, send_yellow_reg;
	wire        out_valid_reg, conditioned, chan_invert_state;
	wire        lsb_signalling_enabled, lsb_signalling_disabled;
	wire  [7:0] out_data_reg;
	int         error_cnt, tests_run, i;
	// design and far end
	tas_alarm_channel #(.TICK_CYCLES(10)) dut (.core_clk, .reset, .frame_lost_pin,
		.far_alarm_pin, .esf_mode, .declaration_time_setting, .clearing_time_setting,
		.remote_alarm_release_choice, .aggregate_link, .chan_cfg_we, .chan_cfg_idx,
		.chan_cfg_rbs, .chan_cfg_invert, .xconn_we, .xconn_idx, .xconn_kind, .pay_valid,
		.pay_frame, .pay_chan, .pay_data, .pay_sig_bit, .red_alarm_reg, .yellow_alarm_reg,
		.send_yellow_reg, .out_valid_reg, .out_data_reg, .lsb_signalling_enabled,
		.lsb_signalling_disabled, .chan_invert_state);
	tas_far_end u_far (.lose_frame, .far_fault, .send_yellow(send_yellow_reg),
		.frame_lost_pin, .far_alarm_pin, .conditioned);
	// compare, count, verdict
	task chk(input logic [8:0] got, input logic [8:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task close_out;
		if (error_cnt == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// stream, config and readback accesses
	task send(input [4:0] f, input [4:0] c, input [7:0] d, input s, input [7:0] e);
		@(posedge core_clk);
		pay_valid <= 1'b1;
		pay_frame <= f;
		pay_chan <= c;
		chan_cfg_idx <= c;
		pay_data <= d;
		pay_sig_bit <= s;
		@(posedge core_clk);
		pay_valid <= 1'b0;
		@(negedge core_clk);
		chk({out_valid_reg, out_data_reg}, {1'b1, e});
	endtask
	task cfg(input [4:0] c, input r, input v);
		@(posedge core_clk);
		chan_cfg_we <= 1'b1;
		chan_cfg_idx <= c;
		chan_cfg_rbs <= r;
		chan_cfg_invert <= v;
		@(posedge core_clk);
		chan_cfg_we <= 1'b0;
	endtask
	task xc(input [4:0] c, input [2:0] k);
		@(posedge core_clk);
		xconn_we <= 1'b1;
		xconn_idx <= c;
		xconn_kind <= k;
		@(posedge core_clk);
		xconn_we <= 1'b0;
	endtask
	task rd(input [4:0] c, input [2:0] e);
		@(posedge core_clk);
		chan_cfg_idx <= c;
		@(negedge core_clk);
		chk({6'h00, lsb_signalling_enabled, lsb_signalling_disabled, chan_invert_state}, {6'h00, e});
	endtask
	// bounded wait on red (y=0) or yellow (y=1)
	task wt(input y, input v, input int mx);
		int k;
		for (k = 0; k < mx && (y ? yellow_alarm_reg : red_alarm_reg) !== v; k++)
			@(negedge core_clk);
		chk({8'h00, y ? yellow_alarm_reg : red_alarm_reg}, {8'h00, v});
	endtask
	// one red fault, resync, and release of the yellow sent
	task run_red(input e, input ch, input ys);
		@(posedge core_clk);
		esf_mode <= e;
		remote_alarm_release_choice <= ch;
		lose_frame <= 1'b1;
		repeat (15) @(negedge core_clk);
		chk({8'h00, red_alarm_reg}, 9'h000);
		wt(0, 1, 40);
		@(negedge core_clk);
		chk({7'h00, send_yellow_reg, conditioned}, 9'h003);
		@(posedge core_clk);
		lose_frame <= 1'b0;
		repeat (8) @(negedge core_clk);
		chk({7'h00, red_alarm_reg, send_yellow_reg}, {7'h00, 1'b1, ys});
		wt(0, 0, 40);
		@(negedge core_clk);
		chk({8'h00, send_yellow_reg}, 9'h000);
	endtask
	initial
	begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	// timeout guard
	initial
	begin
		repeat (20000) @(posedge core_clk);
		error_cnt++;
		close_out;
	end
	// main sequence
	initial
	begin
		{reset, aggregate_link} = 2'h3;
		{esf_mode, remote_alarm_release_choice, chan_cfg_we, chan_cfg_rbs} = 4'h0;
		{chan_cfg_invert, xconn_we, pay_valid, pay_sig_bit, lose_frame, far_fault} = 6'h00;
		{chan_cfg_idx, xconn_idx, pay_frame, pay_chan, xconn_kind, pay_data} = 31'h0;
		declaration_time_setting = 9'h003;
		clearing_time_setting = 9'h002;
		repeat (8) @(posedge core_clk);
		reset <= 1'b0;
		rd(5'h00, 3'h4);
		send(5'h06, 5'h00, 8'ha5, 1'b0, 8'ha4);
		send(5'h0c, 5'h00, 8'h5a, 1'b1, 8'h5b);
		send(5'h12, 5'h00, 8'h5a, 1'b1, 8'h5a);
		@(posedge core_clk);
		esf_mode <= 1'b1;
		for (i = 1; i < 5; i++)
			send(5'(6 * i), 5'h01, 8'hff, 1'b0, 8'hfe);
		send(5'h07, 5'h01, 8'h3c, 1'b1, 8'h3c);
		cfg(5'h17, 1'b0, 1'b1);
		send(5'h06, 5'h17, 8'h3c, 1'b1, 8'hc3);
		foreach (xt[j])
		begin
			cfg(5'(j + 2), xt[j][4], xt[j][3]);
			xc(5'(j + 2), xt[j][7:5]);
			rd(5'(j + 2), xt[j][2:0]);
		end
		run_red(1'b1, 1'b1, 1'b1);
		run_red(1'b1, 1'b0, 1'b0);
		run_red(1'b0, 1'b0, 1'b1);
		@(posedge core_clk);
		far_fault <= 1'b1;
		repeat (250) @(negedge core_clk);
		chk({8'h00, yellow_alarm_reg}, 9'h000);
		wt(1, 1, 40);
		@(posedge core_clk);
		far_fault <= 1'b0;
		repeat (5) @(negedge core_clk);
		chk({8'h00, yellow_alarm_reg}, 9'h001);
		wt(1, 0, 40);
		close_out;
	end
endmodule // tas_alarm_channel_tb_top
bind tas_alarm_channel tas_alarm_checker u_chk (.core_clk, .reset, .frame_lost_pin,
	.far_alarm_pin, .esf_mode, .chan_cfg_idx, .pay_valid, .pay_frame, .pay_chan, .pay_data,
	.pay_sig_bit, .red_alarm_reg, .yellow_alarm_reg, .send_yellow_reg, .out_valid_reg,
	.out_data_reg, .lsb_signalling_enabled, .lsb_signalling_disabled, .chan_invert_state);
